// ---- dv/sequential_port_pointer_control_tb.sv ----
// Purpose: directed checks of pointer, access and flag behaviour
// Assumes: checks wait out the pin synchroniser latency
// Notes: pin sequences keep their order, so results are latency-free
`timescale 1ns/1ps
`include "spp_defs.svh"
module sequential_port_pointer_control_tb;
  import spp_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic stop = 1'b0;
  logic clr = 1'b0;
  logic [1:0] fwr = 2'b00;
  logic [1:0] fdat = 2'b11;
  logic clk_en = 1'b1;
  logic [12:0] b1_start = 13'h0010;
  logic [12:0] b1_end = 13'h0012;
  logic [12:0] b2_start = 13'h0020;
  logic [12:0] b2_end = 13'h0020;
  spp_ptr_ctl_t ptr_ctl;
  spp_acc_ctl_t acc_ctl;
  logic oe_n, oe, f1, f2, stopped;
  logic [12:0] addr, ptr;
  logic [15:0] wdat, rdat;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  always #2.5 sys_clk_in = ~sys_clk_in;
  spp_ctl_model u_ctl (.sys_clk_in(sys_clk_in), .ptr_ctl_out(ptr_ctl), .acc_ctl_out(acc_ctl),
    .oe_n_out(oe_n), .addr_out(addr), .data_out(wdat));
  spp_seq_port dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en),
    .ptr_ctl_in(ptr_ctl), .acc_ctl_in(acc_ctl), .seq_output_enable_n_in(oe_n),
    .load_addr_in(addr), .wr_data_in(wdat), .buf1_start_in(b1_start), .buf1_end_in(b1_end),
    .buf2_start_in(b2_start), .buf2_end_in(b2_end), .stop_in(stop),
    .internal_counter_clear_in(clr), .flag_wr_in(fwr), .flag_wr_data_in(fdat),
    .rd_data_out(rdat), .rd_data_oe_out(oe), .pointer_out(ptr),
    .buffer_one_end_flag_out(f1), .buffer_two_end_flag_out(f2), .stopped_out(stopped));
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wr(input logic c, input logic [15:0] d);
    u_ctl.step({1'b1, c, 2'b11}, 1'b0, 1'b0, 13'h0000, d);
  endtask
  task automatic rd(input logic c);
    u_ctl.step({1'b1, c, 2'b11}, 1'b0, 1'b1, 13'h0000, 16'h0000);
  endtask
  task automatic ld(input logic [12:0] a);
    u_ctl.step(4'b0111, 1'b1, 1'b1, a, 16'h0000);
  endtask
  // Settle long enough for two sync flops plus the output register
  task automatic settle();
    u_ctl.idle(6);
  endtask
  task automatic pulse(input int which, input logic [1:0] d);
    @(posedge sys_clk_in);
    #1;
    if (which == 0) stop = 1'b1;
    if (which == 1) clr = 1'b1;
    if (which == 2) begin
      fwr = 2'b11;
      fdat = d;
    end
    @(posedge sys_clk_in);
    #1;
    stop = 1'b0;
    clr = 1'b0;
    fwr = 2'b00;
    settle();
  endtask
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk_in);
    #1;
    rst_n_in = 1'b1;
    settle();
    check(16'(ptr), 16'h0000, "ptr after reset");
    check(16'(oe), 16'h0000, "oe after reset");
    check(16'({f2, f1}), 16'h0000, "flags after reset");
    wr(1'b0, 16'ha5a5);
    wr(1'b0, 16'h5a5a);
    settle();
    check(16'(ptr), 16'h0002, "ptr after two writes");
    u_ctl.set_oe(1'b0);
    ld(13'h0000);
    rd(1'b0);
    settle();
    check(16'(ptr), 16'h0000, "no step after load");
    check(rdat, 16'ha5a5, "word at 0");
    check(16'(oe), 16'h0001, "oe on read");
    rd(1'b0);
    rd(1'b0);
    settle();
    check(rdat, 16'h5a5a, "word at 1");
    check(16'(ptr), 16'h0002, "ptr steps by one");
    u_ctl.set_oe(1'b1);
    rd(1'b1);
    settle();
    check(16'(oe), 16'h0000, "oe gated");
    check(16'(ptr), 16'h0002, "count held");
    u_ctl.set_oe(1'b0);
    ld(13'h0005);
    wr(1'b1, 16'h1111);
    wr(1'b1, 16'h2222);
    settle();
    check(16'(oe), 16'h0000, "write disables oe");
    check(16'(ptr), 16'h0005, "load then held writes");
    rd(1'b1);
    settle();
    check(rdat, 16'h2222, "rewrite same place");
    u_ctl.step(4'b1101, 1'b1, 1'b1, 13'h0000, 16'h0000);
    rd(1'b0);
    settle();
    check(16'(ptr), 16'h0011, "start one then count");
    u_ctl.step(4'b1110, 1'b1, 1'b1, 13'h0000, 16'h0000);
    settle();
    check(16'(ptr), 16'h0020, "start two");
    check(16'(f2), 16'h0001, "start reaches end two");
    ld(13'h0011);
    u_ctl.idle(1);
    rd(1'b0);
    ld(13'h0000);
    settle();
    check(16'(f1), 16'h0001, "end flag sticks");
    pulse(2, 2'b11);
    check(16'({f2, f1}), 16'h0003, "one leaves flags");
    pulse(2, 2'b10);
    check(16'({f2, f1}), 16'h0002, "zero clears flag one only");
    pulse(2, 2'b01);
    check(16'({f2, f1}), 16'h0000, "zero clears flag two");
    ld(13'h0007);
    settle();
    pulse(0, 2'b11);
    rd(1'b0);
    settle();
    check(16'({stopped, ptr}), 16'h2007, "stopped port holds");
    pulse(1, 2'b11);
    check(16'({stopped, ptr}), 16'h0000, "restart clears");
    rd(1'b0);
    settle();
    check(16'(ptr), 16'h0001, "runs after restart");
    // Second reset with drive enabled: write state must keep outputs off
    rst_n_in = 1'b0;
    u_ctl.idle(3);
    rst_n_in = 1'b1;
    settle();
    check(16'(oe), 16'h0000, "no drive until read clocked");
    check(16'(ptr), 16'h0000, "ptr zero after second reset");
    rd(1'b0);
    settle();
    check(rdat, 16'ha5a5, "first read hits address 0");
    check(16'(oe), 16'h0001, "drive after read clocked");
    check(16'(ptr), 16'h0001, "read steps to address 1");
    // Enable low: pins are not even sampled
    clk_en = 1'b0;
    rd(1'b0);
    settle();
    clk_en = 1'b1;
    settle();
    check(16'(ptr), 16'h0001, "frozen while enable low");
    report_and_stop();
  end
endmodule // sequential_port_pointer_control_tb

// ---- dv/spp_ctl_model.sv ----
// Purpose: sequential-side controller driving the port pins
// Assumes: pins change 1 ns after the rising edge
// Notes: released address and data lines toggle so stale values never match
`timescale 1ns/1ps
`include "spp_defs.svh"
module spp_ctl_model
  import spp_pkg::*;
(
  input wire logic sys_clk_in, // Clock
  output spp_ptr_ctl_t ptr_ctl_out, // Pointer pins
  output spp_acc_ctl_t acc_ctl_out, // Access pins
  output logic oe_n_out, // Output enable pin
  output logic [`SPP_ADDR_W-1:0] addr_out, // Load address
  output logic [`SPP_DATA_W-1:0] data_out // Write data
);
  initial begin
    ptr_ctl_out = '1;
    acc_ctl_out = '1;
    oe_n_out = 1'b1;
    addr_out = '0;
    data_out = '0;
  end
  // One pin cycle; read/write only moves with a select, so recovery leaves it at its last value
  task automatic step(input logic [3:0] p, input logic cs_n, input logic rw,
                      input logic [`SPP_ADDR_W-1:0] a, input logic [`SPP_DATA_W-1:0] d);
    @(posedge sys_clk_in);
    #1;
    ptr_ctl_out = p;
    acc_ctl_out.seq_chip_select_n = cs_n;
    if (!cs_n) acc_ctl_out.seq_read_write = rw;
    addr_out = a;
    data_out = d;
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge sys_clk_in);
      #1;
      ptr_ctl_out = '1;
      acc_ctl_out.seq_chip_select_n = 1'b1;
      addr_out = ~addr_out;
      data_out = ~data_out;
    end
  endtask
  task automatic set_oe(input logic v);
    oe_n_out = v;
  endtask
endmodule // spp_ctl_model

// ---- hw/spp_defs.svh ----
// Purpose: constants for the sequential port pointer control
// Assumes: included by bare name
// Notes: pointer widths follow an 8K-word array by default
`ifndef SPP_DEFS_SVH
`define SPP_DEFS_SVH
`define SPP_ADDR_W 13
`define SPP_DATA_W 16
`define SPP_PTR_RST 13'h0000
`define SPP_RW_RST 1'b0
`define SPP_BUF1_START_RST 13'h0000
`define SPP_BUF1_END_RST 13'h0fff
`define SPP_BUF2_START_RST 13'h1000
`define SPP_BUF2_END_RST 13'h1fff
`define SPP_FLAG_B1 0
`define SPP_FLAG_B2 1
`endif

// ---- hw/spp_pkg.sv ----
// Purpose: shared types for the sequential port pointer control
// Assumes: spp_defs.svh gives the widths
// Notes: types only
`include "spp_defs.svh"
package spp_pkg;
  typedef struct packed {
    logic pointer_load_n;
    logic count_advance_n;
    logic buffer_one_start_n;
    logic buffer_two_start_n;
  } spp_ptr_ctl_t;
  typedef struct packed {
    logic seq_chip_select_n;
    logic seq_read_write;
  } spp_acc_ctl_t;
  typedef enum logic [1:0] {
    SPP_IDLE,
    SPP_READ,
    SPP_WRITE
  } spp_acc_t;
endpackage

// ---- hw/spp_seq_port.sv ----
// Functional notes
// RULE1 - Low pointer load captures presented address
// RULE2 - High count enable holds the pointer
// RULE3 - No increment in cycle after load
// RULE4 - Buffer start loads that buffer's start
// RULE5 - Buffer start does not block next count
// RULE6 - Registered read outputs addressed word
// RULE7 - Registered write stores data at pointer
// RULE8 - Output enable gates data outputs
// RULE9 - Registered write disables outputs until read
// RULE10 - Held count repeats writes same location
// RULE11 - Reset forces internal state to write
// RULE12 - Pointer addresses location zero after reset
// RULE13 - Second write after reset lands address one
// RULE14 - Second read after reset reads address one
// RULE15 - Counter clear restarts stopped port
// RULE16 - Host writes zero bit four restarts
// RULE17 - Controller idles during restart recovery
// RULE18 - Flag bits show end-of-buffer reached
// RULE19 - Zero clears flag, one leaves it
// RULE20 - Low count enable increments by one
// RULE21 - End flag sets at end, sticks
//
// Purpose: sequential port pointer, access decode, memory and end flags
// Assumes: pins pass two flops; restart comes as a clear pulse from the random side
// Notes: pin-to-action latency is two cycles from the synchroniser
`timescale 1ns/1ps
`include "spp_defs.svh"
module spp_seq_port
  import spp_pkg::*;
#(
  parameter int AW = `SPP_ADDR_W,
  parameter int DW = `SPP_DATA_W
) (
  input wire logic sys_clk_in, // 200 MHz clock
  input wire logic rst_n_in, // Async reset, low
  input wire logic clk_en_in, // Freezes state when low
  input wire spp_ptr_ctl_t ptr_ctl_in, // Pointer controls, active low
  input wire spp_acc_ctl_t acc_ctl_in, // Chip select and read/write
  input wire logic seq_output_enable_n_in, // Output enable, low
  input wire logic [AW-1:0] load_addr_in, // Address for pointer load
  input wire logic [DW-1:0] wr_data_in, // Write data
  input wire logic [AW-1:0] buf1_start_in, // Buffer one start
  input wire logic [AW-1:0] buf1_end_in, // Buffer one end
  input wire logic [AW-1:0] buf2_start_in, // Buffer two start
  input wire logic [AW-1:0] buf2_end_in, // Buffer two end
  input wire logic stop_in, // Stop mode from random side
  input wire logic internal_counter_clear_in, // Counter release cleared, pulse
  input wire logic [1:0] flag_wr_in, // Flag status write strobe
  input wire logic [1:0] flag_wr_data_in, // Flag status write bits
  output logic [DW-1:0] rd_data_out, // Read data
  output logic rd_data_oe_out, // Data drive enable, high drives
  output logic [AW-1:0] pointer_out, // Current pointer
  output logic buffer_one_end_flag_out, // Buffer one end reached
  output logic buffer_two_end_flag_out, // Buffer two end reached
  output logic stopped_out // Port stopped
);
  localparam int DEPTH = 1 << AW;
  localparam int PW = 3 + AW + DW + 1;

  logic [DW-1:0] mem [DEPTH];
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_s;
  spp_ptr_ctl_t pc;
  spp_acc_ctl_t ac;
  logic oe_n;
  logic [AW-1:0] la;
  logic [DW-1:0] wd;

  // Pins cross into the clock domain before anything reads them
  assign pin_raw = {ptr_ctl_in.pointer_load_n, ptr_ctl_in.buffer_one_start_n,
                    ptr_ctl_in.buffer_two_start_n, load_addr_in, wr_data_in,
                    seq_output_enable_n_in};
  spp_sync2 #(.W(PW), .RST({3'b111, {AW{1'b0}}, {DW{1'b0}}, 1'b1})) u_sync_pins (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .d_in(pin_raw),
    .q_out(pin_s)
  );
  logic [2:0] ctl_raw;
  logic [2:0] ctl_s;
  assign ctl_raw = {ptr_ctl_in.count_advance_n, acc_ctl_in.seq_chip_select_n,
                    acc_ctl_in.seq_read_write};
  spp_sync2 #(.W(3), .RST(3'b110)) u_sync_ctl (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .d_in(ctl_raw),
    .q_out(ctl_s)
  );
  always_comb begin
    pc.pointer_load_n = pin_s[PW-1];
    pc.buffer_one_start_n = pin_s[PW-2];
    pc.buffer_two_start_n = pin_s[PW-3];
    la = pin_s[DW+AW:DW+1];
    wd = pin_s[DW:1];
    oe_n = pin_s[0];
    pc.count_advance_n = ctl_s[2];
    ac.seq_chip_select_n = ctl_s[1];
    ac.seq_read_write = ctl_s[0];
  end

  // Pointer group
  logic [AW-1:0] ptr_ff, nxt_ptr;
  logic after_load_ff, nxt_after_load;
  logic stopped_ff, nxt_stopped;
  logic rw_ff, nxt_rw;
  spp_acc_t acc;

  always_comb begin
    nxt_ptr = ptr_ff;
    nxt_after_load = 1'b0;
    nxt_stopped = stopped_ff;
    if (internal_counter_clear_in) begin
      nxt_stopped = 1'b0; // [RULE15] [RULE16]
      nxt_ptr = '0;
    end else if (stop_in) begin
      nxt_stopped = 1'b1;
    end else if (!stopped_ff) begin
      if (!pc.pointer_load_n) begin
        nxt_ptr = la; // [RULE1]
        nxt_after_load = 1'b1;
      end else if (!pc.buffer_one_start_n) begin
        nxt_ptr = buf1_start_in; // [RULE4] [RULE5]
      end else if (!pc.buffer_two_start_n) begin
        nxt_ptr = buf2_start_in; // [RULE4]
      end else if (!pc.count_advance_n && !after_load_ff) begin
        nxt_ptr = ptr_ff + 1'b1; // [RULE20] [RULE3] [RULE13] [RULE14]
      end
      // High count enable leaves pointer as is [RULE2] [RULE10]
    end
    nxt_rw = ac.seq_chip_select_n ? rw_ff : ac.seq_read_write;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr_ff <= `SPP_PTR_RST; // [RULE12]
      after_load_ff <= 1'b0;
      stopped_ff <= 1'b0;
      rw_ff <= `SPP_RW_RST; // [RULE11]
    end else if (clk_en_in) begin
      ptr_ff <= nxt_ptr;
      after_load_ff <= nxt_after_load;
      stopped_ff <= nxt_stopped;
      rw_ff <= nxt_rw;
    end
  end

  always_comb begin
    if (stopped_ff || ac.seq_chip_select_n) begin
      acc = SPP_IDLE;
    end else if (ac.seq_read_write) begin
      acc = SPP_READ;
    end else begin
      acc = SPP_WRITE;
    end
  end

  // Memory array; write uses pointer of this cycle
  always_ff @(posedge sys_clk_in) begin
    if (clk_en_in) begin
      case (acc)
        SPP_WRITE: mem[ptr_ff] <= wd; // [RULE7] [RULE10] [RULE13]
        default: begin
        end
      endcase
    end
  end

  // Output group
  logic [DW-1:0] nxt_rd;
  logic nxt_oe;
  always_comb begin
    nxt_rd = rd_data_out;
    case (acc)
      SPP_READ: nxt_rd = mem[ptr_ff]; // [RULE6] [RULE14]
      default: nxt_rd = rd_data_out;
    endcase
    // Registered write blocks drive whatever enable says
    nxt_oe = !oe_n && nxt_rw; // [RULE8] [RULE9] [RULE11]
  end

  // Flag group
  logic [1:0] flag_ff, nxt_flag;
  always_comb begin
    nxt_flag = flag_ff;
    nxt_flag[`SPP_FLAG_B1] = flag_ff[`SPP_FLAG_B1]
      & ~(flag_wr_in[`SPP_FLAG_B1] & ~flag_wr_data_in[`SPP_FLAG_B1]); // [RULE19]
    nxt_flag[`SPP_FLAG_B2] = flag_ff[`SPP_FLAG_B2]
      & ~(flag_wr_in[`SPP_FLAG_B2] & ~flag_wr_data_in[`SPP_FLAG_B2]); // [RULE19]
    // Reaching the end wins over a clear in the same cycle
    if (nxt_ptr == buf1_end_in) begin
      nxt_flag[`SPP_FLAG_B1] = 1'b1; // [RULE18] [RULE21]
    end
    if (nxt_ptr == buf2_end_in) begin
      nxt_flag[`SPP_FLAG_B2] = 1'b1; // [RULE18] [RULE21]
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
      rd_data_oe_out <= 1'b0;
      flag_ff <= 2'h0;
      pointer_out <= '0;
      stopped_out <= 1'b0;
    end else if (clk_en_in) begin
      rd_data_out <= nxt_rd;
      rd_data_oe_out <= nxt_oe;
      flag_ff <= nxt_flag;
      pointer_out <= nxt_ptr;
      stopped_out <= nxt_stopped;
    end
  end
  assign buffer_one_end_flag_out = flag_ff[`SPP_FLAG_B1];
  assign buffer_two_end_flag_out = flag_ff[`SPP_FLAG_B2];

  // Checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_load;
    clk_en_in && !stopped_ff && !internal_counter_clear_in && !stop_in
      && !pc.pointer_load_n |=> ptr_ff == $past(la);
  endproperty
  a_load: assert property (p_load) else $error("pointer load missed"); // [RULE1]

  property p_hold;
    clk_en_in && !internal_counter_clear_in && pc.pointer_load_n
      && pc.buffer_one_start_n && pc.buffer_two_start_n && pc.count_advance_n
      |=> $stable(ptr_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("pointer moved while held"); // [RULE2]

  sequence s_loaded;
    clk_en_in && !stopped_ff && !stop_in && !internal_counter_clear_in
      && !pc.pointer_load_n;
  endsequence
  property p_no_inc_after_load;
    s_loaded ##1 (clk_en_in && pc.pointer_load_n && pc.buffer_one_start_n
      && pc.buffer_two_start_n && !stop_in && !internal_counter_clear_in)
      |=> $stable(ptr_ff);
  endproperty
  a_no_inc_after_load: assert property (p_no_inc_after_load) // [RULE3]
    else $error("pointer moved after load");

  property p_inc;
    clk_en_in && !stopped_ff && !stop_in && !internal_counter_clear_in
      && !after_load_ff && pc.pointer_load_n && pc.buffer_one_start_n
      && pc.buffer_two_start_n && !pc.count_advance_n
      |=> ptr_ff == $past(ptr_ff) + 1'b1;
  endproperty
  a_inc: assert property (p_inc) else $error("pointer did not step by one"); // [RULE20]

  property p_oe_write;
    clk_en_in && !rw_ff |-> !rd_data_oe_out || $past(rw_ff) || $past(!clk_en_in);
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("outputs driven in write"); // [RULE9]

  property p_oe_gate;
    rd_data_oe_out |-> !$past(oe_n);
  endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("drive without enable"); // [RULE8]

  property p_flag_set;
    clk_en_in && nxt_ptr == buf1_end_in |=> buffer_one_end_flag_out;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("end flag not set"); // [RULE21]

  property p_flag_clr;
    clk_en_in && flag_wr_in[0] && !flag_wr_data_in[0] && nxt_ptr != buf1_end_in
      |=> !buffer_one_end_flag_out;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared"); // [RULE19]

  property p_restart;
    clk_en_in && internal_counter_clear_in |=> !stopped_ff && ptr_ff == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart failed"); // [RULE15]

  property p_start;
    clk_en_in && !stopped_ff && !stop_in && !internal_counter_clear_in
      && pc.pointer_load_n && !pc.buffer_one_start_n |=> ptr_ff == $past(buf1_start_in);
  endproperty
  a_start: assert property (p_start) else $error("start one not loaded"); // [RULE4]

  sequence s_started;
    clk_en_in && !stopped_ff && !stop_in && !internal_counter_clear_in
      && pc.pointer_load_n && !pc.buffer_one_start_n;
  endsequence
  property p_count_after_start;
    s_started ##1 (clk_en_in && pc.pointer_load_n && pc.buffer_one_start_n
      && pc.buffer_two_start_n && !pc.count_advance_n && !stop_in
      && !internal_counter_clear_in) |=> ptr_ff == $past(ptr_ff) + 1'b1;
  endproperty
  a_count_after_start: assert property (p_count_after_start) // [RULE5]
    else $error("count blocked after start");

  property p_stop_hold;
    clk_en_in && stopped_ff && !internal_counter_clear_in |=> $stable(ptr_ff);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped pointer moved"); // [RULE15]

  property p_flag2_set;
    clk_en_in && nxt_ptr == buf2_end_in |=> buffer_two_end_flag_out;
  endproperty
  a_flag2_set: assert property (p_flag2_set) else $error("end flag two not set"); // [RULE18]
endmodule // spp_seq_port

// ---- hw/spp_sync2.sv ----
// Purpose: two-flop synchroniser for pin inputs
// Assumes: one clock, clock enable freezes state
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module spp_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic sys_clk_in, // Clock
  input wire logic rst_n_in, // Async reset, low
  input wire logic clk_en_in, // Clock enable
  input wire logic [W-1:0] d_in, // Async level
  output logic [W-1:0] q_out // Synchronised level
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_q;
  always_comb begin
    nxt_meta = clk_en_in ? d_in : meta_ff;
    nxt_q = clk_en_in ? meta_ff : q_out;
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_ff <= RST;
      q_out <= RST;
    end else begin
      meta_ff <= nxt_meta;
      q_out <= nxt_q;
    end
  end
endmodule // spp_sync2
